// ### design/rx_path_defs.svh
// Offsets, field positions, reset values and counts of the receive path.
// Assumes inclusion by bare name from the package and the checker.
`ifndef RX_PATH_DEFS_SVH
`define RX_PATH_DEFS_SVH

`define CH_COUNT 2
`define EB_DEPTH 8
`define EB_PTR_W 4
`define EB_FULL 4'h8
`define EB_LOW_MARK 4'h2
`define EB_HIGH_MARK 4'h6
`define REF_DIV_LAST 4'h9
`define MID_SPAN_CHARS 3'h4
`define HIGH_ADJ_CHARS 3'h4
`define K285_NEG 10'h17c
`define K285_POS 10'h283
`define COMMA_NEG 8'h7c
`define COMMA_POS 8'h83

`define CTRL_ADDR 8'h00
`define STAT_ADDR 8'h04
`define MASK_ADDR 8'h08
`define FILL_ADDR 8'h0c
`define CTRL_RESET 15'h0149
`define CTRL_FMODE 1:0
`define CTRL_FCHAR 3:2
`define CTRL_PAR 5:4
`define CTRL_TX_MODE_SELECT 7:6
`define CTRL_DEC 9:8
`define CTRL_TXCK 11:10
`define CTRL_RXCK 13:12
`define CTRL_REFRAME 14
`define EV_TXERR 0
`define EV_INS 2
`define EV_DEL 4
`define EV_OVF 6

`endif

// ### design/rx_path_pkg.sv
// Types shared by the framer and the receive path top.
// Assumes the constants header is on the include path.
`include "rx_path_defs.svh"
package rx_path_pkg;
  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH, LVL_BAD} level_t;

  typedef struct packed {
    logic [9:0] prev;
    logic [3:0] off;
    logic [3:0] cand;
    logic [2:0] hits;
    logic [2:0] span;
    logic [9:0] char_out;
    logic frame_out;
    logic valid_out;
  } framer_state_t;
endpackage : rx_path_pkg

// ### design/rx_char_framer.sv
// Character framer for one channel.
// Assumes raw bits arrive ten at a time, earliest bit in bit 0.
`timescale 1ns/1ps
module rx_char_framer (
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] raw_bits,
  input wire logic raw_valid,
  input wire logic reframe_en,
  input wire rx_path_pkg::level_t mode,
  input wire rx_path_pkg::level_t char_sel,
  output logic [9:0] char_out,
  output logic frame_out,
  output logic valid_out
);
  rx_path_pkg::framer_state_t st_ff;
  rx_path_pkg::framer_state_t nxt_st;

  function automatic logic is_frame(input logic [9:0] c,
                                    input rx_path_pkg::level_t sel);
    // Comma on 8 bits, else full K28.5, both disparities
    if (sel == rx_path_pkg::LVL_MID)
    begin
      return (c[7:0] == `COMMA_NEG) || (c[7:0] == `COMMA_POS);
    end
    return (c == `K285_NEG) || (c == `K285_POS);
  endfunction : is_frame

  always_comb
  begin
    logic [19:0] win;
    logic hit;
    logic [3:0] hoff;
    nxt_st = st_ff;
    win = {raw_bits, st_ff.prev};
    hit = 1'b0;
    hoff = 4'h0;
    nxt_st.valid_out = 1'b0;
    for (int i = 9; i >= 0; i--)
    begin
      if (is_frame(win[i +: 10], char_sel))
      begin
        hit = 1'b1;
        hoff = 4'(i);
      end
    end
    if (raw_valid)
    begin
      nxt_st.prev = raw_bits;
      if (st_ff.hits != 3'h0 && st_ff.span != 3'h7)
      begin
        nxt_st.span = st_ff.span + 3'h1;
      end
      if (reframe_en && hit)
      begin
        case (mode)
          rx_path_pkg::LVL_LOW:
          begin
            nxt_st.off = hoff;
          end
          rx_path_pkg::LVL_MID:
          begin
            if (st_ff.hits != 3'h0 && st_ff.cand == hoff &&
                st_ff.span < `MID_SPAN_CHARS)
            begin
              nxt_st.off = hoff;
              nxt_st.hits = 3'h0;
            end
            else
            begin
              nxt_st.cand = hoff;
              nxt_st.hits = 3'h1;
              nxt_st.span = 3'h0;
            end
          end
          default:
          begin
            if (st_ff.hits != 3'h0 && st_ff.cand == hoff &&
                st_ff.hits == `HIGH_ADJ_CHARS - 3'h1)
            begin
              nxt_st.off = hoff;
              nxt_st.hits = 3'h0;
            end
            else if (st_ff.hits != 3'h0 && st_ff.cand == hoff)
            begin
              nxt_st.hits = st_ff.hits + 3'h1;
            end
            else
            begin
              nxt_st.cand = hoff;
              nxt_st.hits = 3'h1;
              nxt_st.span = 3'h0;
            end
          end
        endcase
      end
      else if (mode != rx_path_pkg::LVL_MID ||
               st_ff.span >= `MID_SPAN_CHARS - 3'h1)
      begin
        nxt_st.hits = 3'h0;
      end
      nxt_st.char_out = win[nxt_st.off +: 10];
      nxt_st.frame_out = is_frame(nxt_st.char_out, char_sel);
      nxt_st.valid_out = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign char_out = st_ff.char_out;
  assign frame_out = st_ff.frame_out;
  assign valid_out = st_ff.valid_out;
endmodule : rx_char_framer

// ### design/rx_framer_parity_elastic_path.sv
// Two-channel receive framing, parity and elasticity path.
// Assumes one 125 MHz clock; all inputs synchronous to it.
//
// Overview of operation
// - High framing mode realigns after four adjacent same-boundary hits.
// - Alternate framer keeps character cadence; no clock stretching.
// - Middle character select searches 8-bit comma, both disparities.
// - High character select searches full K28.5, both disparities.
// - Parity control low: no checking, receive parity not driven.
// - Middle parity: check data plus parity bit, generate over data.
// - Middle with both codecs bypassed adds type bits and status[1:0].
// - High parity: data, type bits, status[2:0] covered.
// - Transmit clock select low: inputs sampled on reference rate.
// - Receive clock select low: elasticity buffer, reference timing.
// - Buffer compensates only by adding or dropping framing chars.
// - Add: K28.5 inserted right after a framing character.
// - Drop: framing character removed only when it is next at the read pointer.
// - Framers realign only while reframe enable is high.
// - Decoder select low passes raw 10-bit characters out.
// - Middle framing mode needs two hits within 50 bits.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module rx_framer_parity_elastic_path (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic INTERRUPT,
  input wire logic [1:0][9:0] RX_RAW_BITS,
  input wire logic [1:0] RX_RAW_VALID,
  input wire logic [1:0][7:0] TX_DATA_IN,
  input wire logic [1:0][1:0] TX_CHAR_TYPE,
  input wire logic [1:0] TX_PARITY_IN,
  input wire logic [1:0] TX_CHAR_STROBE,
  output logic [1:0] TX_PARITY_ERROR,
  output logic [1:0][7:0] RX_DATA_OUT,
  output logic [1:0][2:0] RX_STATUS_OUT,
  output logic [1:0] RX_PARITY_OUT,
  output logic [1:0] RX_PARITY_OE,
  output logic [1:0] RX_OUT_VALID
);
  typedef struct packed {
    logic [14:0] ctrl;
    logic [7:0] stat;
    logic [7:0] mask;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic [3:0] div;
    logic ref_en;
    logic [1:0][7:0][10:0] mem;
    logic [1:0][3:0] wp;
    logic [1:0][3:0] rp;
    logic [1:0] last_frame;
    logic [1:0] ins_done;
    logic [1:0][7:0] rx_data;
    logic [1:0][2:0] rx_stat;
    logic [1:0] rx_par;
    logic [1:0] rx_oe;
    logic [1:0] rx_valid;
    logic [1:0] tx_err;
  } path_state_t;

  path_state_t st_ff;
  path_state_t nxt_st;

  logic [1:0][9:0] fr_char;
  logic [1:0] fr_frame;
  logic [1:0] fr_valid;
  rx_path_pkg::level_t fmode;
  rx_path_pkg::level_t fchar;
  rx_path_pkg::level_t par_ctl;
  rx_path_pkg::level_t tx_mode;
  rx_path_pkg::level_t dec_sel;
  rx_path_pkg::level_t tx_ck;
  rx_path_pkg::level_t rx_ck;

  assign fmode = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_FMODE]);
  assign fchar = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_FCHAR]);
  assign par_ctl = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_PAR]);
  assign tx_mode = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_TX_MODE_SELECT]);
  assign dec_sel = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_DEC]);
  assign tx_ck = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_TXCK]);
  assign rx_ck = rx_path_pkg::level_t'(st_ff.ctrl[`CTRL_RXCK]);

  // One framer per channel
  generate
    for (genvar ch = 0; ch < `CH_COUNT; ch++)
    begin : g_framer
      rx_char_framer u_framer (
        .clk(CLK),
        .reset(RESET),
        .raw_bits(RX_RAW_BITS[ch]),
        .raw_valid(RX_RAW_VALID[ch]),
        .reframe_en(st_ff.ctrl[`CTRL_REFRAME]),
        .mode(fmode),
        .char_sel(fchar),
        .char_out(fr_char[ch]),
        .frame_out(fr_frame[ch]),
        .valid_out(fr_valid[ch])
      );
    end
  endgenerate

  always_comb
  begin
    logic req;
    logic [31:0] wm;
    logic [7:0] ev;
    logic [7:0] clr;
    logic both_byp;
    logic [3:0] fill;
    logic [10:0] ent;
    logic [3:0] st_mask;
    logic out_en;
    logic ins;
    logic del;
    logic [8:0] bits;
    logic tx_en;
    nxt_st = st_ff;
    req = CYC_I && STB_I && !st_ff.ack;
    wm = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    ev = 8'h00;
    clr = 8'h00;
    both_byp = (tx_mode == rx_path_pkg::LVL_LOW) &&
               (dec_sel == rx_path_pkg::LVL_LOW);
    fill = 4'h0;
    ent = 11'h000;
    st_mask = 4'h0;
    out_en = 1'b0;
    ins = 1'b0;
    del = 1'b0;
    bits = 9'h000;
    tx_en = 1'b0;

    // Reference character rate enable
    nxt_st.ref_en = (st_ff.div == `REF_DIV_LAST);
    nxt_st.div = nxt_st.ref_en ? 4'h0 : st_ff.div + 4'h1;

    // Bus slave, one wait state
    nxt_st.ack = req;
    if (req)
    begin
      case (ADR_I)
        `CTRL_ADDR: nxt_st.rdat = {17'h00000, st_ff.ctrl};
        `STAT_ADDR: nxt_st.rdat = {24'h000000, st_ff.stat};
        `MASK_ADDR: nxt_st.rdat = {24'h000000, st_ff.mask};
        `FILL_ADDR: nxt_st.rdat = {24'h000000,
                                   st_ff.wp[1] - st_ff.rp[1],
                                   st_ff.wp[0] - st_ff.rp[0]};
        default: nxt_st.rdat = 32'h00000000;
      endcase
      if (WE_I)
      begin
        case (ADR_I)
          `CTRL_ADDR: nxt_st.ctrl = (st_ff.ctrl & ~wm[14:0]) |
                                    (DAT_I[14:0] & wm[14:0]);
          `STAT_ADDR: clr = DAT_I[7:0] & wm[7:0];
          `MASK_ADDR: nxt_st.mask = (st_ff.mask & ~wm[7:0]) |
                                    (DAT_I[7:0] & wm[7:0]);
          default: clr = 8'h00;
        endcase
      end
    end

    for (int ch = 0; ch < `CH_COUNT; ch++)
    begin
      tx_en = (tx_ck == rx_path_pkg::LVL_LOW) ? st_ff.ref_en :
              TX_CHAR_STROBE[ch];
      nxt_st.tx_err[ch] = 1'b0;
      if (tx_en)
      begin
        if (par_ctl == rx_path_pkg::LVL_HIGH || both_byp)
        begin
          nxt_st.tx_err[ch] = !(^{TX_DATA_IN[ch], TX_CHAR_TYPE[ch],
                                   TX_PARITY_IN[ch]});
        end
        else
        begin
          nxt_st.tx_err[ch] = !(^{TX_DATA_IN[ch], TX_PARITY_IN[ch]});
        end
        if (par_ctl == rx_path_pkg::LVL_LOW)
        begin
          nxt_st.tx_err[ch] = 1'b0;
        end
      end
      ev[`EV_TXERR + ch] = nxt_st.tx_err[ch];

      // Receive selection: buffered or direct
      fill = st_ff.wp[ch] - st_ff.rp[ch];
      ins = 1'b0;
      del = 1'b0;
      out_en = 1'b0;
      ent = {fr_frame[ch], fr_char[ch]};
      if (rx_ck == rx_path_pkg::LVL_LOW)
      begin
        if (fr_valid[ch])
        begin
          if (fill == `EB_FULL)
          begin
            ev[`EV_OVF + ch] = 1'b1;
          end
          else
          begin
            nxt_st.mem[ch][st_ff.wp[ch][2:0]] = {fr_frame[ch], fr_char[ch]};
            nxt_st.wp[ch] = st_ff.wp[ch] + 4'h1;
          end
        end
        if (st_ff.ref_en)
        begin
          // Only framing characters added or dropped
          if (fill <= `EB_LOW_MARK && st_ff.last_frame[ch] &&
              !st_ff.ins_done[ch])
          begin
            ent = {1'b1, `K285_NEG};
            ins = 1'b1;
            out_en = 1'b1;
            nxt_st.ins_done[ch] = 1'b1;
          end
          else if (fill >= `EB_HIGH_MARK &&
                   st_ff.mem[ch][st_ff.rp[ch][2:0]][10])
          begin
            ent = st_ff.mem[ch][3'(st_ff.rp[ch] + 4'h1)];
            del = 1'b1;
            out_en = 1'b1;
            nxt_st.rp[ch] = st_ff.rp[ch] + 4'h2;
          end
          else if (fill != 4'h0)
          begin
            ent = st_ff.mem[ch][st_ff.rp[ch][2:0]];
            out_en = 1'b1;
            nxt_st.rp[ch] = st_ff.rp[ch] + 4'h1;
          end
          if (out_en && !ins)
          begin
            nxt_st.last_frame[ch] = ent[10];
            nxt_st.ins_done[ch] = 1'b0;
          end
        end
      end
      else
      begin
        out_en = fr_valid[ch];
        nxt_st.rp[ch] = st_ff.wp[ch];
      end
      ev[`EV_INS + ch] = ins;
      ev[`EV_DEL + ch] = del;

      nxt_st.rx_valid[ch] = out_en;
      if (out_en)
      begin
        if (dec_sel == rx_path_pkg::LVL_LOW)
        begin
          nxt_st.rx_data[ch] = ent[7:0];
          nxt_st.rx_stat[ch] = {ent[10], ent[9:8]};
        end
        else
        begin
          nxt_st.rx_data[ch] = ent[7:0];
          nxt_st.rx_stat[ch] = {del, ins, ent[10]};
        end
        st_mask = (par_ctl == rx_path_pkg::LVL_HIGH) ? 4'h7 :
                  both_byp ? 4'h3 : 4'h0;
        bits = {nxt_st.rx_data[ch], 1'b0};
        nxt_st.rx_par[ch] = ~^{bits, nxt_st.rx_stat[ch] & st_mask[2:0]};
      end
      // Parity output released at low control
      nxt_st.rx_oe[ch] = (par_ctl != rx_path_pkg::LVL_LOW);
    end

    // Sticky events; a new event beats the clear
    nxt_st.stat = (st_ff.stat & ~clr) | ev;
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_ff <= '0;
      st_ff.ctrl <= `CTRL_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign DAT_O = st_ff.rdat;
  assign ACK_O = st_ff.ack;
  assign INTERRUPT = st_ff.irq;
  assign TX_PARITY_ERROR = st_ff.tx_err;
  assign RX_DATA_OUT = st_ff.rx_data;
  assign RX_STATUS_OUT = st_ff.rx_stat;
  assign RX_PARITY_OUT = st_ff.rx_par;
  assign RX_PARITY_OE = st_ff.rx_oe;
  assign RX_OUT_VALID = st_ff.rx_valid;
endmodule : rx_framer_parity_elastic_path

// ### testbench/rx_path_monitor.sv
// Checker on the receive path ports; snoops control writes.
// Assumes control writes use all byte lanes.
`timescale 1ns/1ps
`include "rx_path_defs.svh"
module rx_path_monitor (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  input wire logic [1:0][7:0] TX_DATA_IN,
  input wire logic [1:0][1:0] TX_CHAR_TYPE,
  input wire logic [1:0] TX_PARITY_IN,
  input wire logic [1:0] TX_CHAR_STROBE,
  input wire logic [1:0] TX_PARITY_ERROR,
  input wire logic [1:0] RX_RAW_VALID,
  input wire logic [1:0][7:0] RX_DATA_OUT,
  input wire logic [1:0][2:0] RX_STATUS_OUT,
  input wire logic [1:0] RX_PARITY_OUT,
  input wire logic [1:0] RX_PARITY_OE,
  input wire logic [1:0] RX_OUT_VALID
);
  logic [14:0] ctl_ff;
  wire [1:0] par = ctl_ff[5:4];
  wire [1:0] tm = ctl_ff[7:6];
  wire [1:0] dec = ctl_ff[9:8];
  wire [1:0] txck = ctl_ff[11:10];
  wire [1:0] rxck = ctl_ff[13:12];
  wire bypass = tm == 2'h0 && dec == 2'h0;

  // Control copy
  always_ff @(posedge CLK)
    if (RESET)
      ctl_ff <= `CTRL_RESET;
    else if (CYC_I && STB_I && WE_I && !ACK_O && ADR_I == 8'h00)
      ctl_ff <= DAT_I[14:0];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acknowledged");
  ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  parity_oe_a: assert property (
    RX_PARITY_OE == {2{$past(par) != 2'h0}})
    else $error("parity enable wrong");
  no_check_a: assert property (
    par == 2'h0 && $past(par) == 2'h0 |-> TX_PARITY_ERROR == 2'h0)
    else $error("parity error while disabled");
  tx_high_a: assert property (
    par == 2'h2 && txck != 2'h0 && TX_CHAR_STROBE[0] |=> TX_PARITY_ERROR[0]
    == !$past(^{TX_PARITY_IN[0], TX_CHAR_TYPE[0], TX_DATA_IN[0]}))
    else $error("high parity check wrong");
  tx_mid_a: assert property (
    par == 2'h1 && !bypass && txck != 2'h0 && TX_CHAR_STROBE[1]
    |=> TX_PARITY_ERROR[1] == !$past(^{TX_PARITY_IN[1], TX_DATA_IN[1]}))
    else $error("mid parity check wrong");
  rx_high_a: assert property (
    RX_OUT_VALID[0] && par == 2'h2
    |-> ^{RX_PARITY_OUT[0], RX_DATA_OUT[0], RX_STATUS_OUT[0]})
    else $error("rx parity not odd");
  rx_bypass_a: assert property (
    RX_OUT_VALID[0] && par == 2'h1 && bypass
    |-> ^{RX_PARITY_OUT[0], RX_DATA_OUT[0], RX_STATUS_OUT[0][1:0]})
    else $error("rx bypass parity not odd");
  rx_direct_a: assert property (
    rxck != 2'h0 && RX_RAW_VALID[0] |-> ##2 RX_OUT_VALID[0])
    else $error("direct rx latency wrong");

  cover property (TX_PARITY_ERROR[0]);
  cover property (RX_OUT_VALID[0] && rxck == 2'h0);
  cover property (ACK_O && WE_I);
endmodule : rx_path_monitor

// ### testbench/host_side_model.sv
// Host logic on the parallel ports: launches tx words and raw chars.
// Assumes bench commands synchronous to the core clock.
`timescale 1ns/1ps
module host_side_model (
  input wire logic clk,
  input wire logic [1:0] tx_go,
  input wire logic [10:0] tx_word,
  input wire logic [1:0] raw_go,
  input wire logic [9:0] raw_char,
  output logic [1:0][7:0] tx_data = '0,
  output logic [1:0][1:0] tx_type = '0,
  output logic [1:0] tx_par = '0,
  output logic [1:0] tx_strobe = '0,
  output logic [1:0][9:0] raw_bits = '0,
  output logic [1:0] raw_valid = '0
);
  always @(posedge clk)
  begin
    tx_strobe <= tx_go;
    raw_valid <= raw_go;
    for (int c = 0; c < 2; c++)
    begin
      if (tx_go[c])
        {tx_par[c], tx_type[c], tx_data[c]} <= tx_word;
      else
        {tx_par[c], tx_type[c], tx_data[c]} <= ~{tx_par[c], tx_type[c],
                                                 tx_data[c]};
      raw_bits[c] <= raw_go[c] ? raw_char : ~raw_bits[c];
    end
  end
endmodule : host_side_model

// ### testbench/rx_framer_parity_elastic_path_test.sv
// Self-checking bench for the receive path with a host-side model.
// Assumes design, checker and model compiled before it.
`timescale 1ns/1ps
module rx_framer_parity_elastic_path_test;
  logic CLK = 0, RESET = 1, CYC_I = 0, STB_I = 0, WE_I = 0;
  logic [7:0] ADR_I = '0;
  logic [3:0] SEL_I = 4'hf;
  logic [31:0] DAT_I = '0, DAT_O, rd;
  logic ACK_O, INTERRUPT;
  logic [1:0][9:0] RX_RAW_BITS;
  logic [1:0] RX_RAW_VALID, TX_PARITY_IN, TX_CHAR_STROBE, TX_PARITY_ERROR;
  logic [1:0] RX_PARITY_OUT, RX_PARITY_OE, RX_OUT_VALID, tx_go = '0;
  logic [1:0][7:0] TX_DATA_IN, RX_DATA_OUT;
  logic [1:0][1:0] TX_CHAR_TYPE;
  logic [1:0][2:0] RX_STATUS_OUT;
  logic [1:0] raw_go = '0, acc = '0;
  logic [10:0] tx_word = '0, w;
  logic [9:0] raw_char = '0, ch;
  logic [9:0] rq[$];
  logic [7:0] got[$], want[$];
  logic e;
  int mismatches = 0, n_compared = 0, c;
  logic [2:0] rmask = 3'h7;
  bit byp = 0;
  int cfg[4][3] = '{'{2, 1, 1}, '{1, 1, 1}, '{1, 0, 0}, '{0, 1, 1}};

  rx_framer_parity_elastic_path u_rx_framer_parity_elastic_path (
    .CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
    .ACK_O(ACK_O), .INTERRUPT(INTERRUPT), .RX_RAW_BITS(RX_RAW_BITS),
    .RX_RAW_VALID(RX_RAW_VALID), .TX_DATA_IN(TX_DATA_IN),
    .TX_CHAR_TYPE(TX_CHAR_TYPE), .TX_PARITY_IN(TX_PARITY_IN),
    .TX_CHAR_STROBE(TX_CHAR_STROBE), .TX_PARITY_ERROR(TX_PARITY_ERROR),
    .RX_DATA_OUT(RX_DATA_OUT), .RX_STATUS_OUT(RX_STATUS_OUT),
    .RX_PARITY_OUT(RX_PARITY_OUT), .RX_PARITY_OE(RX_PARITY_OE),
    .RX_OUT_VALID(RX_OUT_VALID));

  host_side_model u_host_side_model (
    .clk(CLK), .tx_go(tx_go), .tx_word(tx_word), .raw_go(raw_go),
    .raw_char(raw_char), .tx_data(TX_DATA_IN), .tx_type(TX_CHAR_TYPE),
    .tx_par(TX_PARITY_IN), .tx_strobe(TX_CHAR_STROBE),
    .raw_bits(RX_RAW_BITS), .raw_valid(RX_RAW_VALID));

  initial
    forever #4 CLK = ~CLK;

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge CLK);
    {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, a, d};
    do
      @(posedge CLK);
    while (ACK_O !== 1'b1);
    rd = DAT_O;
    {CYC_I, STB_I, WE_I} <= 3'b000;
  endtask : wb

  task automatic ctrl(input int p, input int tm, input int dc, input int k);
    wb(1'b1, 8'h00, 32'h9 | p << 4 | tm << 6 | dc << 8 | k * 32'h1400);
  endtask : ctrl

  task automatic send_tx(input int ch_no, input logic [10:0] wd,
                         input logic x);
    @(posedge CLK);
    tx_word <= wd;
    tx_go[ch_no] <= 1'b1;
    @(posedge CLK);
    tx_go <= 2'b00;
    @(posedge CLK);
    #1 check("tx error", TX_PARITY_ERROR, {1'b0, x} << ch_no);
  endtask : send_tx

  task automatic raw(input logic [9:0] cv, input int gap);
    @(posedge CLK);
    raw_char <= cv;
    raw_go <= 2'b01;
    @(posedge CLK);
    raw_go <= 2'b00;
    repeat (gap - 2) @(posedge CLK);
  endtask : raw

  always @(posedge CLK)
    if (RX_OUT_VALID[0] === 1'b1 && byp)
    begin
      check("rx data", RX_DATA_OUT[0], rq[0][7:0]);
      check("rx type", RX_STATUS_OUT[0][1:0], rq[0][9:8]);
      check("rx par", RX_PARITY_OUT[0],
            ~^{rq[0][7:0], RX_STATUS_OUT[0] & rmask});
      void'(rq.pop_front());
    end
    else if (RX_OUT_VALID[0] === 1'b1 && RX_DATA_OUT[0] != 8'h7c
             && RX_DATA_OUT[0] != 8'h83)
      got.push_back(RX_DATA_OUT[0]);

  initial
  begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'hc6db));
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    wb(1'b0, 8'h00, '0);
    check("ctrl reset", rd, 32'h149);
    wb(1'b1, 8'h10, '1);
    wb(1'b0, 8'h10, '0);
    check("unmapped", rd, '0);
    $display("test registers done");
    foreach (cfg[i])
    begin
      ctrl(cfg[i][0], cfg[i][1], cfg[i][2], 1);
      repeat (2) @(posedge CLK);
      check("parity oe", RX_PARITY_OE, {2{cfg[i][0] != 0}});
      repeat (12)
      begin
        w = 11'($urandom);
        c = $urandom_range(1);
        e = cfg[i][0] == 2 || cfg[i][0] == 1 && cfg[i][1] == 0 &&
            cfg[i][2] == 0 ? ~^w
            : cfg[i][0] == 1 ? ~^{w[10], w[7:0]} : 1'b0;
        acc[c] = acc[c] | e;
        send_tx(c, w, e);
      end
    end
    wb(1'b0, 8'h04, '0);
    check("tx status", rd[1:0], acc);
    check("irq masked", INTERRUPT, 1'b0);
    wb(1'b1, 8'h08, 32'h3);
    repeat (2) @(posedge CLK);
    check("irq set", INTERRUPT, acc != 2'b00);
    wb(1'b1, 8'h04, 32'h3);
    repeat (2) @(posedge CLK);
    check("irq clear", INTERRUPT, 1'b0);
    $display("test tx parity done");
    // Framer emits previous group first; reset value comes out
    rq.push_back(10'h000);
    for (int k = 0; k < 2; k++)
    begin
      ctrl(2 - k, 1 - k, 0, 1);
      rmask = k ? 3'h3 : 3'h7;
      byp = 1;
      repeat (10)
      begin
        ch = 10'($urandom);
        rq.push_back(ch);
        raw(ch, 3);
      end
      repeat (5) @(posedge CLK);
      check("rx drained", rq.size(), 1);
      byp = 0;
    end
    $display("test rx direct done");
    ctrl(0, 1, 1, 0);
    // Last direct group still held in the framer
    if (rq[0][7:0] != 8'h7c && rq[0][7:0] != 8'h83)
      want.push_back(rq[0][7:0]);
    for (int g = 8; g <= 12; g += 4)
      for (int k = 0; k < 45; k++)
      begin
        ch = k % 3 ? 10'($urandom) : 10'h17c;
        if (ch[7:0] == 8'h83 || k % 3 && ch[7:0] == 8'h7c)
          ch[7:0] = 8'h00;
        if (k % 3)
          want.push_back(ch[7:0]);
        raw(ch, g);
      end
    // Flush last real character out of the framer
    raw(10'h17c, 12);
    repeat (200) @(posedge CLK);
    check("eb count", got.size(), want.size());
    foreach (want[i])
      check("eb data", got[i], want[i]);
    wb(1'b0, 8'h04, '0);
    check("insert seen", rd[2], 1'b1);
    check("drop seen", rd[4], 1'b1);
    $display("test elastic done");
    conclude();
  end
endmodule : rx_framer_parity_elastic_path_test

bind rx_framer_parity_elastic_path rx_path_monitor u_rx_path_monitor (
  .CLK(CLK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_I(DAT_I), .ACK_O(ACK_O), .TX_DATA_IN(TX_DATA_IN),
  .TX_CHAR_TYPE(TX_CHAR_TYPE), .TX_PARITY_IN(TX_PARITY_IN),
  .TX_CHAR_STROBE(TX_CHAR_STROBE), .TX_PARITY_ERROR(TX_PARITY_ERROR),
  .RX_RAW_VALID(RX_RAW_VALID), .RX_DATA_OUT(RX_DATA_OUT),
  .RX_STATUS_OUT(RX_STATUS_OUT), .RX_PARITY_OUT(RX_PARITY_OUT),
  .RX_PARITY_OE(RX_PARITY_OE), .RX_OUT_VALID(RX_OUT_VALID));
